// ==== verilog/fsbp_port.sv ====
/*
  Flow-through synchronous burst SRAM port: input registers, command and
  burst sequencing, late-write pipeline with bypass, output drive control
  and power-down indication around the storage array.
  Assumes the controller runs on core_clk; only the sleep pin and the burst
  order pin are treated as asynchronous. Pads combine data_out and data_oe.
*/
// What this block does
// - Register all synchronous inputs on rising edge
// - Clock qualifier high freezes the whole cycle
// - Reads and writes back to back, no waits
// - Write strobe plus per-lane byte selects
// - Writes complete internally, clocked, self-timed
// - Selected only when all three selects active
// - Output gate tri-states drivers asynchronously
// - Drivers off during every write data phase
// - Drive direction handled internally, no gate toggling
// - Read data flows from array, unregistered
// - Burst order linear or interleaved
// - Power down on sleep or deselect
// - Array 512K x 36 or 1M x 18
`timescale 1ns/10ps
`include "fsbp_defs.svh"

module fsbp_port
  import fsbp_pkg::*;
#(
  parameter int ADDR_W = `FSBP_ADDR_W_WIDE,
  parameter int LANES  = `FSBP_LANES_WIDE
) (
  input  wire logic                           core_clk,
  input  wire logic                           rst_n,
  input  wire logic                           clock_qualify_n,
  input  wire logic [ADDR_W-1:0]              mem_addr,
  input  wire logic                           write_strobe_n,
  input  wire logic [LANES-1:0]               byte_lane_selects_n,
  input  wire logic                           chip_select_first_n,
  input  wire logic                           chip_select_second,
  input  wire logic                           chip_select_third_n,
  input  wire logic                           burst_step_or_fetch,
  input  wire logic                           burst_order_interleave,
  input  wire logic                           output_gate_n,
  input  wire logic                           sleep_request,
  input  wire logic [LANES*`FSBP_LANE_W-1:0]  data_in,
  output logic      [LANES*`FSBP_LANE_W-1:0]  data_out,
  output logic                                data_oe,
  output logic                                power_down
);

  localparam int DW = LANES * `FSBP_LANE_W;
  localparam int LW = `FSBP_LANE_W;

  ////////////////////////////////////////////////////////////////////////////
  // Burst address function

  // Linear wraps by adding the count, interleaved flips bits by it
  function automatic fsbp_burst_t burst_low(
    input fsbp_burst_t base,
    input fsbp_burst_t count,
    input logic        interleave
  );
    fsbp_burst_t res;
    res = interleave ? (base ^ count) : fsbp_burst_t'(base + count);
    return res;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  // Both pins are asynchronous to core_clk; the first flop may go
  // metastable, so logic reads only the second one.
  logic sleep_meta_r;
  logic sleep_sync_r;
  logic order_meta_r;
  logic order_sync_r;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sleep_meta_r <= 1'b0;
      sleep_sync_r <= 1'b0;
    end else begin
      sleep_meta_r <= sleep_request;
      sleep_sync_r <= sleep_meta_r;
    end
  end

  // Static order pin
  // Pin must stay put; a change mid-burst breaks the sequence.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      order_meta_r <= 1'b0;
      order_sync_r <= 1'b0;
    end else begin
      order_meta_r <= burst_order_interleave;
      order_sync_r <= order_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input decode

  wire       edge_taken;
  wire       selected;
  wire       fetch;
  wire       in_burst;
  wire       cmd_is_write;
  wire [LANES-1:0] lanes_sel;

  assign edge_taken   = ~clock_qualify_n;
  // Three select terms
  // Sleep counts as deselect so no command starts while asleep.
  assign selected     = ~chip_select_first_n & chip_select_second &
                        ~chip_select_third_n & ~sleep_sync_r;
  assign fetch        = ~burst_step_or_fetch;
  assign cmd_is_write = ~write_strobe_n;
  assign lanes_sel    = ~byte_lane_selects_n;

  ////////////////////////////////////////////////////////////////////////////
  // Address and command registers

  fsbp_cmd_t         cmd_r;
  fsbp_cmd_t         cmd_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  fsbp_burst_t       cnt_r;
  fsbp_burst_t       cnt_nxt;
  logic [LANES-1:0]  lanes_r;
  logic [LANES-1:0]  lanes_nxt;

  assign in_burst = (cmd_r != FSBP_CMD_IDLE);

  // Command every cycle
  // A new command may replace any other on any taken edge; no turnaround idle.
  always_comb begin
    cmd_nxt   = cmd_r;
    addr_nxt  = addr_r;
    cnt_nxt   = cnt_r;
    lanes_nxt = lanes_r;
    if (edge_taken) begin
      if (fetch) begin
        cnt_nxt   = `FSBP_BURST_START;
        addr_nxt  = mem_addr;
        lanes_nxt = lanes_sel;
        if (!selected) begin
          cmd_nxt = FSBP_CMD_IDLE;
        end else if (cmd_is_write) begin
          cmd_nxt = FSBP_CMD_WRITE;
        end else begin
          cmd_nxt = FSBP_CMD_READ;
        end
      end else if (in_burst) begin
        // Lanes refresh on each step: every write beat has its own selects
        // Burst counter step
        cnt_nxt   = fsbp_burst_t'(cnt_r + `FSBP_BURST_STEP);
        lanes_nxt = lanes_sel;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_r   <= FSBP_CMD_IDLE;
      cnt_r   <= `FSBP_BURST_START;
      addr_r  <= '0;
      lanes_r <= '0;
    end else begin
      cmd_r   <= cmd_nxt;
      cnt_r   <= cnt_nxt;
      addr_r  <= addr_nxt;
      lanes_r <= lanes_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Current beat address

  wire              burst_low_bit_zero;
  wire              burst_low_bit_one;
  wire fsbp_burst_t beat_low;
  wire [ADDR_W-1:0] beat_addr;

  assign beat_low  = burst_low(addr_r[`FSBP_BURST_W-1:0], cnt_r,
                               order_sync_r);
  assign burst_low_bit_zero = beat_low[0];
  assign burst_low_bit_one  = beat_low[1];
  assign beat_addr = {addr_r[ADDR_W-1:`FSBP_BURST_W],
                      burst_low_bit_one, burst_low_bit_zero};

  ////////////////////////////////////////////////////////////////////////////
  // Cycle type decode

  logic beat_read;
  logic beat_write;

  always_comb begin
    case (cmd_r)
      FSBP_CMD_READ: begin
        beat_read  = 1'b1;
        beat_write = 1'b0;
      end
      FSBP_CMD_WRITE: begin
        beat_read  = 1'b0;
        beat_write = 1'b1;
      end
      FSBP_CMD_IDLE: begin
        beat_read  = 1'b0;
        beat_write = 1'b0;
      end
      default: begin
        beat_read  = 1'b0;
        beat_write = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Late write pipeline

  logic              wr_pend_r;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [LANES-1:0]  wr_lanes_r;
  logic [DW-1:0]     wr_data_r;

  // Self-timed commit
  // Data is taken on the edge closing the data phase and lands in the
  // array on the following edge; a held edge repeats the same write.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_pend_r <= 1'b0;
    end else if (edge_taken) begin
      wr_pend_r <= beat_write;
    end
  end

  // Holding flops carry no reset: they are read only while wr_pend_r
  // is set, which reset clears.
  always_ff @(posedge core_clk) begin
    if (edge_taken && beat_write) begin
      wr_addr_r  <= beat_addr;
      wr_lanes_r <= lanes_r;
      wr_data_r  <= data_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Storage

  logic [DW-1:0] array_rd;

  fsbp_array #(
    .ADDR_W (ADDR_W),
    .LANES  (LANES)
  ) u_array (
    .core_clk (core_clk),
    .wr_en    (wr_pend_r),
    .wr_addr  (wr_addr_r),
    .wr_lanes (wr_lanes_r),
    .wr_data  (wr_data_r),
    .rd_addr  (beat_addr),
    .rd_data  (array_rd)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  wire hit;

  // Read after write bypass
  // A read right behind a write sees the not yet committed lanes.
  assign hit = wr_pend_r && (wr_addr_r == beat_addr);

  for (genvar g = 0; g < LANES; g++) begin : g_bypass
    assign data_out[g*LW +: LW] = (hit && wr_lanes_r[g]) ?
                                  wr_data_r[g*LW +: LW] :
                                  array_rd[g*LW +: LW];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output drive and power

  // Direction self-timed
  // Sleep masks the drivers once it has passed both synchroniser flops, even while a read is still held.
  assign data_oe = beat_read & ~output_gate_n & ~sleep_sync_r;

  // Low power state
  // A step keeps the block awake; only a deselected fetch or sleep
  // ends the active state; a selected fetch also cuts a burst in flight short but keeps the block awake.
  assign power_down = sleep_sync_r | ~in_burst;

endmodule

// ==== inc/fsbp_defs.svh ====
/*
  Constants of the flow-through burst SRAM port: organisation, lane layout,
  burst counter width and synchroniser depth.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef FSBP_DEFS_SVH
`define FSBP_DEFS_SVH

// Nine bits per byte lane: eight data bits and one parity bit
`define FSBP_LANE_W        9
`define FSBP_LANE_PAR_BIT  8

// Wide organisation: 512K words of four lanes
`define FSBP_LANES_WIDE    4
`define FSBP_ADDR_W_WIDE   19

// Narrow organisation: 1M words of two lanes
`define FSBP_LANES_NARROW  2
`define FSBP_ADDR_W_NARROW 20

// Burst counter runs on the two low address bits
`define FSBP_BURST_W       2
`define FSBP_BURST_STEP    2'h1
`define FSBP_BURST_START   2'h0

// Asynchronous pins pass this many flip-flops
`define FSBP_SYNC_STAGES   2

`endif

// ==== inc/fsbp_pkg.sv ====
/*
  Types of the flow-through burst SRAM port.
  Assumes fsbp_defs.svh is on the include path.
*/
`include "fsbp_defs.svh"

package fsbp_pkg;

  // Command held for the current cycle, one-hot
  typedef enum logic [2:0] {
    FSBP_CMD_IDLE  = 3'b001,
    FSBP_CMD_READ  = 3'b010,
    FSBP_CMD_WRITE = 3'b100
  } fsbp_cmd_t;

  typedef logic [`FSBP_BURST_W-1:0] fsbp_burst_t;

endpackage

// ==== verilog/fsbp_array.sv ====
/*
  Storage array of the burst SRAM port: flip-flop words addressed by index,
  one clocked write port with per-lane enables, one combinational read port.
  Assumes the port logic presents registered write address, data and lanes.
*/
`timescale 1ns/10ps
`include "fsbp_defs.svh"

module fsbp_array
  import fsbp_pkg::*;
#(
  parameter int ADDR_W = `FSBP_ADDR_W_WIDE,
  parameter int LANES  = `FSBP_LANES_WIDE
) (
  input  wire logic                           core_clk,
  input  wire logic                           wr_en,
  input  wire logic [ADDR_W-1:0]              wr_addr,
  input  wire logic [LANES-1:0]               wr_lanes,
  input  wire logic [LANES*`FSBP_LANE_W-1:0]  wr_data,
  input  wire logic [ADDR_W-1:0]              rd_addr,
  output logic      [LANES*`FSBP_LANE_W-1:0]  rd_data
);

  localparam int LW    = `FSBP_LANE_W;
  localparam int DEPTH = 2**ADDR_W;

  ////////////////////////////////////////////////////////////////////////////
  // Per-lane storage
  // Array holds no reset: contents are undefined until written.
  // One store per lane, so each store has a single writing process.
  for (genvar g = 0; g < LANES; g++) begin : g_lane
    logic [LW-1:0] mem_r [DEPTH];

    always_ff @(posedge core_clk) begin
      if (wr_en && wr_lanes[g]) begin
        mem_r[wr_addr] <= wr_data[g*LW +: LW];
      end
    end

    assign rd_data[g*LW +: LW] = mem_r[rd_addr];
  end

endmodule

// ==== verification/fsbp_port_asserts.sv ====
/* Checker of fsbp_port: drive, select and sleep properties.
   Assumes one clock and the synchronous active-low reset. */
`timescale 1ns/10ps

module fsbp_port_asserts (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clock_qualify_n,
  input wire logic write_strobe_n,
  input wire logic chip_select_first_n,
  input wire logic chip_select_second,
  input wire logic chip_select_third_n,
  input wire logic burst_step_or_fetch,
  input wire logic output_gate_n,
  input wire logic sleep_request,
  input wire logic data_oe,
  input wire logic power_down
);
  logic [2:0] calm_r;
  wire take = !clock_qualify_n;
  wire sel = !chip_select_first_n && chip_select_second
             && !chip_select_third_n;
  // Sleep pin passes a synchroniser, so wait it out
  wire calm = calm_r > 3'h3;

  always_ff @(posedge core_clk) begin
    if (!rst_n || sleep_request)
      calm_r <= 3'h0;
    else if (calm_r != 3'h7)
      calm_r <= calm_r + 3'h1;
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence rd_go;
    take && !burst_step_or_fetch && write_strobe_n && sel && calm;
  endsequence
  sequence wr_go;
    take && !burst_step_or_fetch && !write_strobe_n;
  endsequence
  // Sleep may arrive during the first beat, so the step needs calm too
  sequence step_go;
    take && burst_step_or_fetch && calm;
  endsequence

  chk_gate_off: assert property (output_gate_n |-> !data_oe)
    else $error("drive with gate off");
  chk_write_float: assert property (wr_go |=> !data_oe)
    else $error("drive in write data phase");
  chk_read_drive: assert property (
    rd_go ##1 !output_gate_n |-> data_oe)
    else $error("read not driven");
  chk_burst_drive: assert property (
    rd_go ##1 step_go ##1 !output_gate_n |-> data_oe)
    else $error("burst beat not driven");
  chk_deselect_idle: assert property (
    take && !burst_step_or_fetch && !sel |=> power_down && !data_oe)
    else $error("deselected fetch active");
  chk_power_up: assert property (rd_go |=> !power_down)
    else $error("power down during read");
  chk_sleep_down: assert property (
    (sleep_request && take)[*3] |-> power_down && !data_oe)
    else $error("no power down on sleep");
  chk_freeze_hold: assert property (!take && calm |=>
    $stable(power_down) && ($stable(data_oe) || $changed(output_gate_n)))
    else $error("state moved on ignored edge");
endmodule

bind fsbp_port fsbp_port_asserts u_chk (.core_clk, .rst_n,
  .clock_qualify_n, .write_strobe_n, .chip_select_first_n,
  .chip_select_second, .chip_select_third_n, .burst_step_or_fetch,
  .output_gate_n, .sleep_request, .data_oe, .power_down);

// ==== verification/fsbp_ctl_model.sv ====
/* Controller side of the data bus: drives write data when told to.
   Assumes the bench raises wr_valid for each write data phase. */
`timescale 1ns/10ps

module fsbp_ctl_model #(
  parameter int W = 36
) (
  input  wire logic         core_clk,
  input  wire logic         wr_valid,
  input  wire logic [W-1:0] wr_word,
  output logic      [W-1:0] data_in
);
  logic [W-1:0] last_r;

  always_ff @(posedge core_clk)
    last_r <= data_in;
  // Write data only in its phase
  // Released bus toggles so no stale word can pass for data
  assign data_in = wr_valid ? wr_word : ~last_r;
endmodule

// ==== verification/fsbp_port_tb.sv ====
/* Bench of fsbp_port: fill, turnaround, random bursts, sleep.
   Assumes fsbp_ctl_model supplies write data on data_in. */
`timescale 1ns/10ps
`include "fsbp_defs.svh"

module fsbp_port_tb
  import fsbp_pkg::*;
;
  localparam int AW = 8;
  localparam int LN = `FSBP_LANES_WIDE;
  localparam int LW = `FSBP_LANE_W;
  localparam int W  = LN*LW;
  logic          core_clk, data_oe, power_down, wv = 1'b0;
  logic          rst_n = 1'b0, q_n = 1'b1, stp = 1'b0, we_n = 1'b1;
  logic          c1_n = 1'b1, c2 = 1'b0, c3_n = 1'b1, il = 1'b0;
  logic          g_n = 1'b0, slp = 1'b0;
  logic [AW-1:0] adr = '0, base = '0;
  logic [LN-1:0] ln_n = '0;
  logic [W-1:0]  data_in, data_out, wd = '0, wq = '0;
  logic [W-1:0]  mem [16];
  logic [1:0]    cmd = 2'h0;
  fsbp_burst_t   cnt = 2'h0;
  int            error_cnt = 0, checks = 0, ticks = 0;

  fsbp_port #(.ADDR_W(AW), .LANES(LN)) DUT (
    .core_clk(core_clk), .rst_n(rst_n), .clock_qualify_n(q_n),
    .mem_addr(adr), .write_strobe_n(we_n), .byte_lane_selects_n(ln_n),
    .chip_select_first_n(c1_n), .chip_select_second(c2),
    .chip_select_third_n(c3_n), .burst_step_or_fetch(stp),
    .burst_order_interleave(il), .output_gate_n(g_n),
    .sleep_request(slp), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .power_down(power_down));
  fsbp_ctl_model #(.W(W)) u_ctl (.core_clk(core_clk), .wr_valid(wv),
    .wr_word(wq), .data_in(data_in));

  //////////////////////////////////////////////////////////////////////
  function automatic logic [AW-1:0] baddr(logic [AW-1:0] b, fsbp_burst_t n);
    baddr = {b[AW-1:2], il ? b[1:0] ^ n : b[1:0] + n};
  endfunction

  function automatic logic [W-1:0] merge(logic [W-1:0] o, w,
                                         logic [LN-1:0] s_n);
    merge = o;
    for (int g = 0; g < LN; g++)
      if (!s_n[g])
        merge[LW*g +: LW] = w[LW*g +: LW];
  endfunction

  task automatic cmp1(string n, logic e, logic g);
    checks++;
    if (e !== g) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %b got %b", n, e, g);
    end
  endtask

  task automatic cmpw(string n, logic [W-1:0] e, logic [W-1:0] g);
    checks++;
    if (e !== g) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Model the edge just taken, then drive the next cycle and check it
  task automatic cyc(logic q, s, w, logic [2:0] c, logic g,
                     logic [AW-1:0] a, logic [LN-1:0] l);
    logic [AW-1:0] ba;
    @(posedge core_clk);
    if (!q_n) begin
      if (!stp) begin
        cmd = (c1_n | !c2 | c3_n) ? 2'h0 : (we_n ? 2'h1 : 2'h2);
        base = adr;
        cnt = 2'h0;
      end else if (cmd != 2'h0)
        cnt = cnt + 2'h1;
      ba = baddr(base, cnt);
      if (cmd == 2'h2) begin
        wd = W'({$urandom, $urandom});
        mem[ba[3:0]] = merge(mem[ba[3:0]], wd, ln_n);
      end
    end
    ba = baddr(base, cnt);
    wv <= (cmd == 2'h2);
    wq <= wd;
    q_n <= q;
    stp <= s;
    we_n <= w;
    g_n <= g;
    adr <= a;
    ln_n <= l;
    c1_n <= (c == 3'h1);
    c2 <= (c != 3'h2);
    c3_n <= (c == 3'h3);
    @(negedge core_clk);
    cmp1("data_oe", cmd == 2'h1 && !g, data_oe);
    cmp1("power_down", cmd == 2'h0, power_down);
    if (cmd == 2'h1 && !g)
      cmpw("data_out", mem[ba[3:0]], data_out);
  endtask

  //////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    ticks++;
    if (ticks == 2000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    logic [31:0] r;
    void'($urandom(99563));
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int a = 0; a < 16; a++)
      cyc(1'b0, 1'b0, 1'b0, 3'h0, 1'b0, AW'(a), 4'h0);
    $display("test fill done");
    cyc(1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 8'h0f, 4'h0);
    cyc(1'b0, 1'b0, 1'b0, 3'h0, 1'b0, 8'h05, 4'ha);
    cyc(1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 8'h05, 4'h0);
    $display("test turnaround done");
    for (int p = 0; p < 2; p++) begin
      cyc(1'b0, 1'b0, 1'b1, 3'h1, 1'b0, 8'h00, 4'h0);
      il <= p[0];
      repeat (3) cyc(1'b0, 1'b0, 1'b1, 3'h2, 1'b0, 8'h00, 4'h0);
      for (int i = 0; i < 200; i++) begin
        r = $urandom;
        cyc(r[2:0] == 3'h0, r[3], r[4], r[7:5], r[9:8] == 2'h3,
            AW'(r[15:12]), r[19:16]);
      end
      $display("test burst order %0d done", p);
    end
    cyc(1'b0, 1'b0, 1'b1, 3'h0, 1'b0, 8'h03, 4'h0);
    slp <= 1'b1;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    cmp1("sleep data_oe", 1'b0, data_oe);
    cmp1("sleep power_down", 1'b1, power_down);
    $display("test sleep done");
    give_verdict();
  end
endmodule
